// ---- design/damp_pkg.sv ----
// package: register map, field layout and timing counts of the amplifier control block
package damp_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_AMP_A_CTL   = 8'h00;
    localparam logic [7:0] OFS_AMP_B_CTL   = 8'h04;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
    localparam logic [7:0] OFS_RESULT_LOW  = 8'h0C;
    localparam logic [7:0] OFS_STATUS      = 8'h10;

    // control register fields
    localparam int         BIT_ENABLE   = 7;
    localparam int         BIT_SHORT    = 6;
    localparam int         BIT_GAIN_HI  = 5;
    localparam int         BIT_GAIN_LO  = 4;
    localparam int         BIT_TRIG_HI  = 1;
    localparam int         BIT_TRIG_LO  = 0;
    localparam logic [7:0] CTL_WMASK    = 8'hF3;
    localparam logic [7:0] CTL_RESET    = 8'h00;

    // status register fields
    localparam int         BIT_ST_BUSY  = 0;
    localparam int         BIT_ST_CH    = 1;
    localparam int         BIT_ST_EN_A  = 2;
    localparam int         BIT_ST_EN_B  = 3;

    // trigger source codes
    localparam logic [1:0] TRIG_AUTO    = 2'h0;
    localparam logic [1:0] TRIG_STAGE0  = 2'h1;
    localparam logic [1:0] TRIG_STAGE1  = 2'h2;
    localparam logic [1:0] TRIG_STAGE2  = 2'h3;

    // conversion timing in converter clock cycles, and the converter clock divider in system clock cycles
    localparam logic [3:0] CONV_CYC_LOW  = 4'hD;
    localparam logic [3:0] CONV_CYC_HIGH = 4'hE;
    localparam logic [3:0] CONV_CYC_TRIG = 4'hD;
    localparam logic [3:0] SAMPLE_CYC    = 4'h2;
    localparam logic [2:0] SYNC_RISE_PH  = 3'h3;
    localparam int         CONV_CLK_DIV  = 4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [3:0] {
        CV_IDLE   = 4'b0001,
        CV_WAIT   = 4'b0010,
        CV_RUN    = 4'b0100,
        CV_STABLE = 4'b1000
    } damp_conv_state_t;

endpackage

// ---- design/damp_sync.sv ----
// two-flop synchroniser with rising-edge detect for pins from outside the clock domain
module damp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // asynchronous input
    input  wire logic [W-1:0] pin_in,
    // synchronised level and rising edge
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } damp_sync_state_t;

    damp_sync_state_t s_reg;
    damp_sync_state_t s_next;

    always_comb
    begin
        s_next      = s_reg;
        s_next.meta = pin_in;
        s_next.sync = s_reg.meta;
        s_next.prev = s_reg.sync;
        s_next.rise = s_reg.sync & ~s_reg.prev;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign level = s_reg.sync;
    assign rise  = s_reg.rise;
endmodule

// ---- design/damp_clkdiv.sv ----
// converter clock enable and its divide-by-8 phase
module damp_clkdiv
    import damp_pkg::*;
#(
    parameter int ADC_DIV = CONV_CLK_DIV
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // enables and the slow clock phase level
    output logic      adc_tick,
    output logic      sync_tick,
    output logic      slow_high
);
    typedef struct packed {
        logic [7:0] pre;
        logic [2:0] phase;
        logic       tick;
        logic       sync;
    } damp_div_state_t;

    localparam logic [7:0] PRE_LAST = 8'(ADC_DIV - 1);

    damp_div_state_t s_reg;
    damp_div_state_t s_next;

    always_comb
    begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        s_next.sync = 1'b0;
        if (s_reg.pre == PRE_LAST)
        begin
            s_next.pre   = 8'h00;
            s_next.tick  = 1'b1;
            s_next.phase = s_reg.phase + 3'h1;
            // the slow clock rises when the phase moves into its upper half
            s_next.sync  = (s_reg.phase == SYNC_RISE_PH);
        end
        else
            s_next.pre = s_reg.pre + 8'h01;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign adc_tick  = s_reg.tick;
    assign sync_tick = s_reg.sync;
    assign slow_high = s_reg.phase[2];
endmodule

// ---- design/damp_top.sv ----
// amplifier channel control: AXI4-Lite registers and amplified conversion sequencer
module damp_top
    import damp_pkg::*;
#(
    parameter int ADC_DIV = CONV_CLK_DIV
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // conversion request from the converter control logic
    input  wire logic        conv_start,
    input  wire logic        conv_channel,
    // analog side pins
    input  wire logic [9:0]  adc_code,
    input  wire logic        amp_out_changed,
    input  wire logic        stage_ctrl0_async_event,
    input  wire logic        stage_ctrl1_async_event,
    input  wire logic        stage_ctrl2_async_event,
    // amplifier controls
    output logic             amp_a_enable,
    output logic             amp_b_enable,
    output logic             amp_a_input_short,
    output logic             amp_b_input_short,
    output logic [1:0]       amp_a_gain,
    output logic [1:0]       amp_b_gain,
    output logic [5:0]       amp_a_gain_factor,
    output logic [5:0]       amp_b_gain_factor,
    output logic             amp_a_sync,
    output logic             amp_b_sync,
    // conversion status and result
    output logic             conv_sample,
    output logic             conv_busy,
    output logic             conv_done,
    output logic [1:0]       conv_result_high,
    output logic [7:0]       conv_result_low
);
    typedef struct packed {
        logic [1:0][7:0]  ctl;
        logic [1:0]       en_eff;
        logic [1:0]       amp_sync;
        logic             awready;
        logic             wready;
        logic             aw_full;
        logic             w_full;
        logic [7:0]       aw_addr;
        logic [7:0]       wdata;
        logic             wstrb0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        damp_conv_state_t cv;
        logic             ch;
        logic [3:0]       cnt;
        logic [3:0]       target;
        logic             sample;
        logic             done;
        logic [9:0]       result;
        logic [1:0][5:0]  factor;
        logic             busy;
    } damp_state_t;

    damp_state_t s_reg;
    damp_state_t s_next;

    logic       adc_tick;
    logic       sync_tick;
    logic       slow_high;
    logic [2:0] evt_level;
    logic [2:0] evt_rise;
    logic       chg_level;
    logic [9:0] code_sync;

    damp_clkdiv #(
        .ADC_DIV   (ADC_DIV)
    ) u_div (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .adc_tick  (adc_tick),
        .sync_tick (sync_tick),
        .slow_high (slow_high)
    );

    damp_sync #(
        .W       (3)
    ) u_evt_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  ({stage_ctrl2_async_event, stage_ctrl1_async_event,
                   stage_ctrl0_async_event}),
        .level   (evt_level),
        .rise    (evt_rise)
    );

    damp_sync #(
        .W       (11)
    ) u_ana_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  ({amp_out_changed, adc_code}),
        .level   ({chg_level, code_sync}),
        .rise    ()
    );

    // gain code to amplification factor
    function automatic logic [5:0] gain_factor(input logic [1:0] code);
        unique case (code)
            2'h0:    gain_factor = 6'h05;
            2'h1:    gain_factor = 6'h0A;
            2'h2:    gain_factor = 6'h14;
            2'h3:    gain_factor = 6'h28;
        endcase
    endfunction

    // synchronisation event of the selected source
    function automatic logic trig_hit(input logic [1:0] code, input logic auto_evt,
                                      input logic [2:0] stage_evt);
        unique case (code)
            TRIG_AUTO:   trig_hit = auto_evt;
            TRIG_STAGE0: trig_hit = stage_evt[0];
            TRIG_STAGE1: trig_hit = stage_evt[1];
            TRIG_STAGE2: trig_hit = stage_evt[2];
        endcase
    endfunction

    function automatic logic [1:0] trig_of(input logic [7:0] ctl);
        trig_of = ctl[BIT_TRIG_HI:BIT_TRIG_LO];
    endfunction

    always_comb
    begin
        logic       hit;
        logic [7:0] wr_val;
        hit    = 1'b0;
        wr_val = 8'h00;
        s_next = s_reg;
        s_next.sample = 1'b0;
        s_next.done   = 1'b0;

        // write address and data are taken independently, in either order
        if (s_reg.awready && s_axi_awvalid)
        begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid)
        begin
            s_next.w_full = 1'b1;
            s_next.wdata  = s_axi_wdata[7:0];
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready)
            s_next.bvalid = 1'b0;
        if (s_next.aw_full && s_next.w_full && !s_next.bvalid)
        begin
            s_next.aw_full = 1'b0;
            s_next.w_full  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            wr_val         = s_next.wdata & CTL_WMASK;
            unique case (s_next.aw_addr)
                OFS_AMP_A_CTL:
                    if (s_next.wstrb0)
                        s_next.ctl[0] = wr_val;
                OFS_AMP_B_CTL:
                    if (s_next.wstrb0)
                        s_next.ctl[1] = wr_val;
                OFS_RESULT_HIGH, OFS_RESULT_LOW, OFS_STATUS:
                    s_next.bresp = RESP_OKAY;
                default:
                    s_next.bresp = RESP_SLVERR;
            endcase
        end
        s_next.awready = !s_next.aw_full && !s_next.bvalid;
        s_next.wready  = !s_next.w_full && !s_next.bvalid;

        // read channel
        if (s_reg.rvalid && s_axi_rready)
            s_next.rvalid = 1'b0;
        if (s_reg.arready && s_axi_arvalid)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            s_next.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                OFS_AMP_A_CTL:   s_next.rdata[7:0] = s_reg.ctl[0];
                OFS_AMP_B_CTL:   s_next.rdata[7:0] = s_reg.ctl[1];
                OFS_RESULT_HIGH: s_next.rdata[1:0] = s_reg.result[9:8];
                OFS_RESULT_LOW:  s_next.rdata[7:0] = s_reg.result[7:0];
                OFS_STATUS:
                begin
                    s_next.rdata[BIT_ST_BUSY] = !(s_reg.cv == CV_IDLE);
                    s_next.rdata[BIT_ST_CH]   = s_reg.ch;
                    s_next.rdata[BIT_ST_EN_A] = s_reg.en_eff[0];
                    s_next.rdata[BIT_ST_EN_B] = s_reg.en_eff[1];
                end
                default:         s_next.rresp = RESP_SLVERR;
            endcase
        end
        s_next.arready = !s_next.rvalid;

        // amplifier clocking: one pulse per selected event while enabled
        for (int i = 0; i < 2; i++)
            s_next.amp_sync[i] = s_reg.en_eff[i] &&
                trig_hit(trig_of(s_reg.ctl[i]), sync_tick, evt_rise);

        // conversion sequencer
        hit = trig_hit(trig_of(s_reg.ctl[s_reg.ch]), sync_tick, evt_rise);
        unique case (s_reg.cv)
            CV_IDLE:
                if (conv_start && s_reg.ctl[conv_channel][BIT_ENABLE])
                begin
                    s_next.ch  = conv_channel;
                    s_next.cnt = 4'h0;
                    if (trig_of(s_reg.ctl[conv_channel]) == TRIG_AUTO)
                    begin
                        // automatic sync: phase of the slow clock sets the length
                        s_next.cv     = CV_RUN;
                        s_next.target = slow_high ? CONV_CYC_HIGH : CONV_CYC_LOW;
                    end
                    else
                        s_next.cv = CV_WAIT;
                end
            CV_WAIT:
                if (hit)
                begin
                    s_next.cv     = CV_RUN;
                    s_next.cnt    = 4'h0;
                    s_next.target = CONV_CYC_TRIG;
                end
            CV_RUN:
                if (chg_level && s_reg.cnt < SAMPLE_CYC)
                    s_next.cv = CV_STABLE;
                else if (adc_tick)
                begin
                    s_next.cnt    = s_reg.cnt + 4'h1;
                    s_next.sample = (s_reg.cnt == SAMPLE_CYC - 4'h1);
                    if (s_reg.cnt == s_reg.target - 4'h1)
                    begin
                        s_next.cv     = CV_IDLE;
                        s_next.done   = 1'b1;
                        s_next.result = code_sync;
                    end
                end
            CV_STABLE:
                // restart from a fresh synchronisation event once settled
                if (!chg_level)
                    s_next.cv = CV_WAIT;
        endcase

        // a cleared enable holds the amplifier on until its conversion ends
        for (int i = 0; i < 2; i++)
            s_next.en_eff[i] = s_next.ctl[i][BIT_ENABLE] ||
                (s_reg.en_eff[i] && !(s_next.cv == CV_IDLE) && (s_next.ch == i));

        // decoded outputs are registered so every pin comes from a flop
        for (int i = 0; i < 2; i++)
            s_next.factor[i] = gain_factor(s_next.ctl[i][BIT_GAIN_HI:BIT_GAIN_LO]);
        s_next.busy = !(s_next.cv == CV_IDLE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_reg     <= '0;
            s_reg.ctl <= {CTL_RESET, CTL_RESET};
            s_reg.cv  <= CV_IDLE;
            s_reg.factor <= {6'h05, 6'h05};
        end
        else
            s_reg <= s_next;
    end

    assign s_axi_awready     = s_reg.awready;
    assign s_axi_wready      = s_reg.wready;
    assign s_axi_bvalid      = s_reg.bvalid;
    assign s_axi_bresp       = s_reg.bresp;
    assign s_axi_arready     = s_reg.arready;
    assign s_axi_rvalid      = s_reg.rvalid;
    assign s_axi_rdata       = s_reg.rdata;
    assign s_axi_rresp       = s_reg.rresp;
    assign amp_a_enable      = s_reg.en_eff[0];
    assign amp_b_enable      = s_reg.en_eff[1];
    assign amp_a_input_short = s_reg.ctl[0][BIT_SHORT];
    assign amp_b_input_short = s_reg.ctl[1][BIT_SHORT];
    assign amp_a_gain        = s_reg.ctl[0][BIT_GAIN_HI:BIT_GAIN_LO];
    assign amp_b_gain        = s_reg.ctl[1][BIT_GAIN_HI:BIT_GAIN_LO];
    assign amp_a_gain_factor = s_reg.factor[0];
    assign amp_b_gain_factor = s_reg.factor[1];
    assign amp_a_sync        = s_reg.amp_sync[0];
    assign amp_b_sync        = s_reg.amp_sync[1];
    assign conv_sample       = s_reg.sample;
    assign conv_busy         = s_reg.busy;
    assign conv_done         = s_reg.done;
    assign conv_result_high  = s_reg.result[9:8];
    assign conv_result_low   = s_reg.result[7:0];
endmodule

// ---- sim/damp_top_asserts.sv ----
// concurrent checks on the ports of the amplifier control block
module damp_top_asserts
    import damp_pkg::*;
#(
    parameter int ADC_DIV = CONV_CLK_DIV
) (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // register bus
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // conversion
    input wire logic       conv_start,
    input wire logic       conv_channel,
    input wire logic       conv_sample,
    input wire logic       conv_busy,
    input wire logic       conv_done,
    // amplifier controls
    input wire logic       amp_a_enable,
    input wire logic       amp_b_enable,
    input wire logic       amp_a_input_short,
    input wire logic [1:0] amp_a_gain,
    input wire logic [1:0] amp_b_gain,
    input wire logic [5:0] amp_a_gain_factor,
    input wire logic [5:0] amp_b_gain_factor,
    input wire logic       amp_a_sync,
    input wire logic       amp_b_sync
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // channel of the conversion in flight; starts while busy are ignored by the block
    logic ch_reg;
    always_ff @(posedge clk_sys)
        if (conv_start && !conv_busy)
            ch_reg <= conv_channel;

    a_gain_decode: assert property (
        amp_a_gain_factor == (6'h05 << amp_a_gain) && amp_b_gain_factor == (6'h05 << amp_b_gain))
        else $error("gain factor does not follow gain code");
    a_reset_zero: assert property ($fell(sys_rst) |->
        !amp_a_enable && !amp_b_enable && !amp_a_input_short && amp_a_gain == 2'h0
        && amp_b_gain == 2'h0 && !conv_busy)
        else $error("outputs not zero after reset");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_b_refuses: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while response pending");
    a_rd_upper_zero: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
    a_done_ends_busy: assert property (conv_done |-> !conv_busy && $past(conv_busy))
        else $error("busy does not end with done");
    a_no_early_done: assert property ($rose(conv_busy) |-> !conv_done [*8])
        else $error("conversion finished too early");
    a_sample_in_busy: assert property (conv_sample |-> conv_busy)
        else $error("sample phase outside a conversion");
    a_sync_enabled: assert property (
        (amp_a_sync |-> amp_a_enable || $past(amp_a_enable))
        and (amp_b_sync |-> amp_b_enable || $past(amp_b_enable)))
        else $error("sync pulse on a disabled amplifier");
    a_enable_defer: assert property (conv_busy && !ch_reg |-> !$fell(amp_a_enable))
        else $error("amplifier switched off during its conversion");
endmodule

bind damp_top damp_top_asserts #(.ADC_DIV(ADC_DIV)) u_damp_top_asserts (.*);

// ---- sim/damp_far_model.sv ----
// far side model: converter start requests, result pins, settling flag and stage events
module damp_far_model (
    // clock
    input  wire logic  clk_sys,
    // converter control side
    output logic       conv_start,
    output logic       conv_channel,
    output logic [9:0] adc_code,
    // analog side
    output logic       amp_out_changed,
    output logic       stage_ctrl0_async_event,
    output logic       stage_ctrl1_async_event,
    output logic       stage_ctrl2_async_event
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        conv_start = 1'b0;
        conv_channel = 1'b0;
        adc_code = 10'h000;
        amp_out_changed = 1'b0;
        {stage_ctrl2_async_event, stage_ctrl1_async_event, stage_ctrl0_async_event} = 3'h0;
    end

    // code stays on the pins until the next request so the late capture sees it
    task automatic start(input logic ch, input logic [9:0] code);
        @(posedge clk_sys);
        conv_start <= 1'b1;
        conv_channel <= ch;
        adc_code <= code;
        @(posedge clk_sys);
        conv_start <= 1'b0;
        conv_channel <= ~ch;
    endtask

    // held four cycles so the pin synchroniser surely sees the edge
    task automatic evt(input int idx);
        @(posedge clk_sys);
        stage_ctrl0_async_event <= (idx == 0);
        stage_ctrl1_async_event <= (idx == 1);
        stage_ctrl2_async_event <= (idx == 2);
        repeat (4) @(posedge clk_sys);
        {stage_ctrl2_async_event, stage_ctrl1_async_event, stage_ctrl0_async_event} <= 3'h0;
    endtask

    task automatic disturb(input logic lvl);
        @(posedge clk_sys);
        amp_out_changed <= lvl;
    endtask
endmodule

// ---- sim/damp_top_bench.sv ----
// self-checking bench for the amplifier control block
module damp_top_bench
    import damp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, sys_rst;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        conv_start, conv_channel, amp_out_changed;
    logic [9:0]  adc_code;
    logic        stage_ctrl0_async_event, stage_ctrl1_async_event, stage_ctrl2_async_event;
    logic        amp_a_enable, amp_b_enable, amp_a_input_short, amp_b_input_short;
    logic        amp_a_sync, amp_b_sync, conv_sample, conv_busy, conv_done;
    logic [1:0]  amp_a_gain, amp_b_gain, conv_result_high;
    logic [5:0]  amp_a_gain_factor, amp_b_gain_factor;
    logic [7:0]  conv_result_low;
    int          err_count, cmp_count, n;

    // converter tick every clock keeps conversions short
    damp_top #(.ADC_DIV(1)) u_damp_top (.*);
    damp_far_model u_damp_far_model (.*);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(inout int cnt);
        @(posedge clk_sys);
        cnt++;
        if (cnt > 400)
        begin
            err_count++;
            $display("ERROR %0t wait limit hit", $time);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int cnt = 0;
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do
        begin
            tick(cnt);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int cnt = 0;
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do
        begin
            tick(cnt);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er, "rresp");
        chk(s_axi_rdata, ed, "rdata");
    endtask

    task automatic wait_done(output int cnt);
        cnt = 0;
        do tick(cnt); while (conv_done !== 1'b1);
    endtask

    initial
    begin
        err_count = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(OFS_AMP_A_CTL, 32'h0, RESP_OKAY);
        rd(OFS_AMP_B_CTL, 32'h0, RESP_OKAY);
        chk(amp_a_gain_factor, 32'h5, "gain after reset");
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'hFF, RESP_SLVERR);
        wr(OFS_RESULT_LOW, 32'hFF, RESP_OKAY);
        rd(OFS_RESULT_LOW, 32'h0, RESP_OKAY);
        // unused bits fall away, enable, short and gain reach the pins
        wr(OFS_AMP_A_CTL, 32'hFF, RESP_OKAY);
        rd(OFS_AMP_A_CTL, 32'hF3, RESP_OKAY);
        chk({amp_a_enable, amp_a_input_short, amp_a_gain}, 32'hF, "a pins");
        for (int g = 0; g < 4; g++)
        begin
            wr(OFS_AMP_B_CTL, {24'h0, 1'b1, g[0], g[1:0], 4'h0}, RESP_OKAY);
            chk(amp_b_gain_factor, 32'h5 << g, "gain factor");
            chk(amp_b_input_short, g[0], "input short");
            chk(amp_b_enable, 1'b1, "b enable");
        end
        wr(OFS_AMP_B_CTL, 32'h0, RESP_OKAY);
        u_damp_far_model.start(1'b1, 10'h3FF);
        repeat (4) @(posedge clk_sys);
        chk(conv_busy, 1'b0, "start on disabled channel");
        wr(OFS_AMP_A_CTL, 32'h80, RESP_OKAY);
        u_damp_far_model.start(1'b0, 10'h2A5);
        wait_done(n);
        chk(n >= 13 && n <= 16, 1'b1, "auto conversion length");
        rd(OFS_RESULT_HIGH, 32'h2, RESP_OKAY);
        rd(OFS_RESULT_LOW, 32'hA5, RESP_OKAY);
        chk({conv_result_high, conv_result_low}, 32'h2A5, "result pins");
        for (int t = 1; t < 4; t++)
        begin
            wr(OFS_AMP_A_CTL, 32'h80 | t, RESP_OKAY);
            u_damp_far_model.start(1'b0, 10'h100 | t);
            u_damp_far_model.evt(t % 3);
            repeat (20) @(posedge clk_sys);
            chk(conv_busy, 1'b1, "waits for its own event");
            u_damp_far_model.evt(t - 1);
            wait_done(n);
            rd(OFS_RESULT_LOW, t, RESP_OKAY);
        end
        // output moving through the sample phase forces a restart
        wr(OFS_AMP_A_CTL, 32'h80, RESP_OKAY);
        u_damp_far_model.disturb(1'b1);
        repeat (3) @(posedge clk_sys);
        u_damp_far_model.start(1'b0, 10'h3C3);
        repeat (12) @(posedge clk_sys);
        u_damp_far_model.disturb(1'b0);
        wait_done(n);
        chk(n > 16, 1'b1, "restart after settling");
        rd(OFS_RESULT_LOW, 32'hC3, RESP_OKAY);
        u_damp_far_model.start(1'b0, 10'h155);
        wr(OFS_AMP_A_CTL, 32'h0, RESP_OKAY);
        chk(amp_a_enable, 1'b1, "enable held while converting");
        rd(OFS_STATUS, 32'h5, RESP_OKAY);
        wait_done(n);
        repeat (2) @(posedge clk_sys);
        chk(amp_a_enable, 1'b0, "enable dropped after conversion");
        wr(OFS_AMP_B_CTL, 32'hA0, RESP_OKAY);
        u_damp_far_model.start(1'b1, 10'h0F0);
        wait_done(n);
        rd(OFS_RESULT_LOW, 32'hF0, RESP_OKAY);
        rd(OFS_AMP_A_CTL, 32'h0, RESP_OKAY);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(OFS_AMP_B_CTL, 32'h0, RESP_OKAY);
        print_verdict();
    end
endmodule
